// ===== rtl/rx_fifo_cfg.svh
// Register map, field positions and reset values of the receive FIFO path.
`ifndef RX_FIFO_CFG_SVH
`define RX_FIFO_CFG_SVH

// ==========================================================================
// Register byte addresses
`define ADDR_RX_DATA_PORT 8'h00
`define ADDR_RX_STATUS_PORT 8'h04
`define ADDR_FILL_INFO 8'h08
`define ADDR_RX_CONFIG 8'h0C
`define ADDR_DP_CONTROL 8'h10
`define ADDR_MAC_CONTROL 8'h14
`define ADDR_PATH_STATUS 8'h18
`define ADDR_SOFT_RESET 8'h1C

// ==========================================================================
// Field positions
`define CFG_OFFSET_MSB 4
`define CFG_OFFSET_LSB 0
`define CFG_OFFSET_WORD_MSB 4
`define CFG_OFFSET_WORD_LSB 2
`define CFG_OFFSET_LANE_MSB 1
`define CFG_OFFSET_LANE_LSB 0
`define CFG_PAD_EN_BIT 7
`define CFG_BURST_MSB 13
`define CFG_BURST_LSB 8
`define CFG_DUMP_BIT 15
`define DP_FFWD_BIT 31
`define MAC_RX_ENABLE_BIT_BIT 2
`define STAT_ERR_BIT 0
`define STAT_HALTED_BIT 1
`define SRST_BIT 0
`define INFO_DATA_MSB 15
`define INFO_DATA_LSB 0
`define INFO_STAT_MSB 23
`define INFO_STAT_LSB 16

// ==========================================================================
// Reset values
`define RST_OFFSET 5'h00
`define RST_PAD_EN 1'b0
`define RST_BURST 6'h04
`define RST_RX_ENABLE_BIT 1'b0
`define RST_WORD 32'h0000_0000
`define RST_LEN 14'h0000

`endif

// ===== rtl/rx_fifo_pkg.sv
// Types shared by the receive FIFO path.
package rx_fifo_pkg;

   // ========================================================================
   // Fill-side sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LEAD = 3'b001,
      ST_DATA = 3'b010,
      ST_PAD = 3'b011,
      ST_STAT = 3'b100
   } fill_state_t;

   // ========================================================================
   // Per-frame flags delivered by the MAC with the last byte
   typedef struct packed {
      logic filterFail;
      logic broadcast;
      logic lengthErr;
      logic runt;
      logic multicast;
      logic tooLong;
      logic lateColl;
      logic frameType;
      logic watchdog;
      logic miiErr;
      logic dribble;
      logic crcErr;
   } frame_flags_t;

   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } rx_byte_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } host_req_t;

endpackage

// ===== rtl/rx_fifo_ram.sv
// Simple dual-port word memory with registered, write-first read data.
`timescale 1ns/10ps
module rx_fifo_ram #(
   parameter int WIDTH = 32,
   parameter int AW = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write side
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // Read side
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // A word written into the slot being read shows at once, so an empty FIFO that
   // just took a word never presents stale data.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else if (we && (waddr == raddr)) begin
         q <= wdata;
      end else begin
         q <= mem[raddr];
      end
   end

endmodule

// ===== rtl/rx_fifo_path.sv
// Receive data and status FIFOs between the MAC interface layer and the host port.
`timescale 1ns/10ps
`include "rx_fifo_cfg.svh"
module rx_fifo_path #(
   parameter int DATA_AW = 9,
   parameter int STAT_AW = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // MAC interface layer side
   input wire rx_fifo_pkg::rx_byte_t macByte,
   input wire rx_fifo_pkg::frame_flags_t macFlags,
   output logic rxReady,
   // Host register port
   input wire rx_fifo_pkg::host_req_t hostReq,
   output logic [31:0] rdData,
   // Events
   output logic rxErrorFlag,
   output logic rxHaltIrq
);

   localparam logic [DATA_AW:0] DATA_DEPTH = (DATA_AW+1)'(1 << DATA_AW);
   localparam logic [DATA_AW:0] READY_MARGIN = (DATA_AW+1)'(2);
   localparam logic [STAT_AW:0] STAT_DEPTH = (STAT_AW+1)'(1 << STAT_AW);

   // ========================================================================
   // Declarations
   rx_fifo_pkg::fill_state_t state, next_state;
   logic softRst, pathRst_n;
   logic [4:0] cfgOffset;
   logic cfgPadEn;
   logic [5:0] cfgBurst;
   logic dumpBit, ffwdBit, rxEnable, halted;
   logic [DATA_AW:0] dWr, dRd, next_dRd, dCount;
   logic [STAT_AW:0] sWr, sRd, next_sRd, sCount;
   logic [32:0] dQ;
   logic [31:0] sQ;
   logic [1:0] lane;
   logic [31:0] acc, wordNow;
   logic [2:0] leadCnt;
   logic [5:0] burstCnt, burstNext;
   logic [13:0] pktLen;
   rx_fifo_pkg::frame_flags_t flags;
   logic byteTaken, hostDataRd, hostStatRd, dPop, sPop;
   logic dWe, dLast, sWe, statOverrun, underrun;
   logic [31:0] dWord, statWord;
   logic dRoom, sRoom, needPad;

   // Soft reset acts one cycle after its write and clears all path state.
   assign pathRst_n = rst_n && !softRst;

   assign dCount = dWr - dRd;
   assign sCount = sWr - sRd;
   assign dRoom = dCount != DATA_DEPTH;
   assign sRoom = sCount != STAT_DEPTH;
   assign byteTaken = macByte.valid && rxReady && (state == rx_fifo_pkg::ST_DATA);
   assign hostDataRd = hostReq.rd && (hostReq.addr == `ADDR_RX_DATA_PORT);
   assign hostStatRd = hostReq.rd && (hostReq.addr == `ADDR_RX_STATUS_PORT);
   // Data reads during a fast-forward are ignored rather than popped.
   assign dPop = (dCount != '0) && (ffwdBit || hostDataRd);
   assign sPop = hostStatRd && (sCount != '0);
   assign underrun = (hostDataRd && (dCount == '0) && !ffwdBit)
      || (hostStatRd && (sCount == '0));
   assign statOverrun = (state == rx_fifo_pkg::ST_STAT) && !sRoom;
   assign next_dRd = dRd + (DATA_AW+1)'(dPop);
   assign next_sRd = sRd + (STAT_AW+1)'(sPop);
   assign burstNext = (burstCnt + 6'h01 == cfgBurst) ? 6'h00 : burstCnt + 6'h01;
   assign needPad = cfgPadEn && (burstNext != 6'h00);

   // Byte lane insertion; unused leading lanes keep whatever the accumulator held.
   always_comb begin
      wordNow = acc;
      wordNow[{lane, 3'b000} +: 8] = macByte.data;
   end

   // ========================================================================
   // Fill sequencer
   always_comb begin
      next_state = state;
      dWe = 1'b0;
      dLast = 1'b0;
      dWord = acc;
      sWe = 1'b0;
      unique case (state)
         rx_fifo_pkg::ST_IDLE: begin
            // New frames only start while enabled, so a halt lands on a boundary.
            if (macByte.valid && rxEnable) begin
               if (cfgOffset[`CFG_OFFSET_WORD_MSB:`CFG_OFFSET_WORD_LSB] != 3'h0) begin
                  next_state = rx_fifo_pkg::ST_LEAD;
               end else begin
                  next_state = rx_fifo_pkg::ST_DATA;
               end
            end
         end
         rx_fifo_pkg::ST_LEAD: begin
            dWe = dRoom;
            if (dRoom
               && (leadCnt + 3'h1 == cfgOffset[`CFG_OFFSET_WORD_MSB:`CFG_OFFSET_WORD_LSB])) begin
               next_state = rx_fifo_pkg::ST_DATA;
            end
         end
         rx_fifo_pkg::ST_DATA: begin
            if (byteTaken) begin
               dWord = wordNow;
               dWe = (lane == 2'h3) || macByte.last;
               dLast = macByte.last && !needPad;
               if (macByte.last) begin
                  next_state = needPad ? rx_fifo_pkg::ST_PAD : rx_fifo_pkg::ST_STAT;
               end
            end
         end
         rx_fifo_pkg::ST_PAD: begin
            dWe = dRoom;
            dLast = burstNext == 6'h00;
            if (dRoom && (burstNext == 6'h00)) begin
               next_state = rx_fifo_pkg::ST_STAT;
            end
         end
         rx_fifo_pkg::ST_STAT: begin
            sWe = sRoom;
            next_state = rx_fifo_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!pathRst_n || dumpBit) begin
         state <= rx_fifo_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Ready is registered, so it drops early enough to leave two free words.
   always_ff @(posedge clk) begin
      if (!pathRst_n || dumpBit) begin
         rxReady <= 1'b0;
      end else begin
         rxReady <= (next_state == rx_fifo_pkg::ST_DATA) && (dCount < DATA_DEPTH - READY_MARGIN);
      end
   end

   // Per-packet counters restart at every packet so offset and padding never drift.
   always_ff @(posedge clk) begin
      if (!pathRst_n || (state == rx_fifo_pkg::ST_IDLE)) begin
         lane <= cfgOffset[`CFG_OFFSET_LANE_MSB:`CFG_OFFSET_LANE_LSB];
         leadCnt <= 3'h0;
         burstCnt <= 6'h00;
         pktLen <= `RST_LEN;
         acc <= `RST_WORD;
      end else begin
         if (byteTaken) begin
            lane <= lane + 2'h1;
            pktLen <= pktLen + 14'h0001;
            acc <= wordNow;
         end
         if (state == rx_fifo_pkg::ST_LEAD && dRoom) begin
            leadCnt <= leadCnt + 3'h1;
         end
         if (dWe) begin
            burstCnt <= burstNext;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!pathRst_n) begin
         flags <= '0;
      end else if (byteTaken && macByte.last) begin
         flags <= macFlags;
      end
   end

   // ========================================================================
   // Status word: bit 31 and 14, 9:8 and 0 read zero.
   assign statWord = {1'b0, flags.filterFail, pktLen,
      flags.runt | flags.tooLong | flags.lateColl | flags.crcErr,
      1'b0, flags.broadcast, flags.lengthErr, flags.runt, flags.multicast,
      2'b00, flags.tooLong, flags.lateColl, flags.frameType, flags.watchdog,
      flags.miiErr, flags.dribble, flags.crcErr, 1'b0};

   // ========================================================================
   // FIFO pointers
   always_ff @(posedge clk) begin
      if (!pathRst_n || dumpBit) begin
         dWr <= '0;
         dRd <= '0;
         sWr <= '0;
         sRd <= '0;
      end else begin
         if (dWe) begin
            dWr <= dWr + (DATA_AW+1)'(1);
         end
         dRd <= next_dRd;
         if (sWe) begin
            sWr <= sWr + (STAT_AW+1)'(1);
         end
         sRd <= next_sRd;
      end
   end

   rx_fifo_ram #(
      .WIDTH(33),
      .AW(DATA_AW)
   ) dataRam (
      .clk(clk),
      .rst_n(pathRst_n),
      .we(dWe),
      .waddr(dWr[DATA_AW-1:0]),
      .wdata({dLast, dWord}),
      .raddr(next_dRd[DATA_AW-1:0]),
      .q(dQ)
   );

   rx_fifo_ram #(
      .WIDTH(32),
      .AW(STAT_AW)
   ) statRam (
      .clk(clk),
      .rst_n(pathRst_n),
      .we(sWe),
      .waddr(sWr[STAT_AW-1:0]),
      .wdata(statWord),
      .raddr(next_sRd[STAT_AW-1:0]),
      .q(sQ)
   );

   // ========================================================================
   // Control registers
   always_ff @(posedge clk) begin
      if (!pathRst_n) begin
         cfgOffset <= `RST_OFFSET;
         cfgPadEn <= `RST_PAD_EN;
         cfgBurst <= `RST_BURST;
         rxEnable <= `RST_RX_ENABLE_BIT;
      end else if (hostReq.wr) begin
         if (hostReq.addr == `ADDR_RX_CONFIG) begin
            cfgOffset <= hostReq.wdata[`CFG_OFFSET_MSB:`CFG_OFFSET_LSB];
            cfgPadEn <= hostReq.wdata[`CFG_PAD_EN_BIT];
            cfgBurst <= hostReq.wdata[`CFG_BURST_MSB:`CFG_BURST_LSB];
         end
         if (hostReq.addr == `ADDR_MAC_CONTROL) begin
            rxEnable <= hostReq.wdata[`MAC_RX_ENABLE_BIT_BIT];
         end
      end
   end

   // The dump completes in the cycle after it is set.
   always_ff @(posedge clk) begin
      if (!pathRst_n || dumpBit) begin
         dumpBit <= 1'b0;
      end else if (hostReq.wr && (hostReq.addr == `ADDR_RX_CONFIG)) begin
         dumpBit <= hostReq.wdata[`CFG_DUMP_BIT];
      end
   end

   // Waits for more words if the head packet is still arriving.
   always_ff @(posedge clk) begin
      if (!pathRst_n || dumpBit) begin
         ffwdBit <= 1'b0;
      end else if (ffwdBit && (dCount != '0) && dQ[32]) begin
         ffwdBit <= 1'b0;
      end else if (hostReq.wr && (hostReq.addr == `ADDR_DP_CONTROL)) begin
         ffwdBit <= hostReq.wdata[`DP_FFWD_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         softRst <= 1'b0;
      end else begin
         softRst <= hostReq.wr && (hostReq.addr == `ADDR_SOFT_RESET)
            && hostReq.wdata[`SRST_BIT];
      end
   end

   // The error flag has no clear of its own: lost sync is only mended by soft reset or rst_n.
   always_ff @(posedge clk) begin
      if (!pathRst_n) begin
         rxErrorFlag <= 1'b0;
      end else if (underrun || statOverrun) begin
         rxErrorFlag <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!pathRst_n) begin
         halted <= 1'b1;
         rxHaltIrq <= 1'b0;
      end else begin
         halted <= !rxEnable && (state == rx_fifo_pkg::ST_IDLE);
         rxHaltIrq <= !rxEnable && (state == rx_fifo_pkg::ST_IDLE) && !halted;
      end
   end

   // ========================================================================
   // Read data
   always_ff @(posedge clk) begin
      if (!pathRst_n || !hostReq.rd) begin
         rdData <= `RST_WORD;
      end else begin
         unique case (hostReq.addr)
            // A data read that collides with a fast-forward pops nothing, so it returns zero.
            `ADDR_RX_DATA_PORT: rdData <= (dPop && !ffwdBit) ? dQ[31:0] : `RST_WORD;
            `ADDR_RX_STATUS_PORT: rdData <= sPop ? sQ : `RST_WORD;
            `ADDR_FILL_INFO: begin
               rdData <= `RST_WORD;
               rdData[`INFO_DATA_MSB:`INFO_DATA_LSB] <= 16'(dCount);
               rdData[`INFO_STAT_MSB:`INFO_STAT_LSB] <= 8'(sCount);
            end
            `ADDR_RX_CONFIG: begin
               rdData <= `RST_WORD;
               rdData[`CFG_OFFSET_MSB:`CFG_OFFSET_LSB] <= cfgOffset;
               rdData[`CFG_PAD_EN_BIT] <= cfgPadEn;
               rdData[`CFG_BURST_MSB:`CFG_BURST_LSB] <= cfgBurst;
               rdData[`CFG_DUMP_BIT] <= dumpBit;
            end
            `ADDR_DP_CONTROL: begin
               rdData <= `RST_WORD;
               rdData[`DP_FFWD_BIT] <= ffwdBit;
            end
            `ADDR_MAC_CONTROL: begin
               rdData <= `RST_WORD;
               rdData[`MAC_RX_ENABLE_BIT_BIT] <= rxEnable;
            end
            `ADDR_PATH_STATUS: begin
               rdData <= `RST_WORD;
               rdData[`STAT_ERR_BIT] <= rxErrorFlag;
               rdData[`STAT_HALTED_BIT] <= halted;
            end
            default: rdData <= `RST_WORD;
         endcase
      end
   end

   // ========================================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!pathRst_n);

   sequence s_last_byte;
      byteTaken && macByte.last;
   endsequence
   sequence s_status_slot;
      state == rx_fifo_pkg::ST_STAT;
   endsequence

   property p_status_follows;
      s_last_byte |-> ##[1:70] s_status_slot ##1 (state == rx_fifo_pkg::ST_IDLE);
   endproperty
   a_status_follows: assert property (p_status_follows) else $error("no status after packet");

   property p_fill_info;
      hostReq.rd && hostReq.addr == `ADDR_FILL_INFO |=>
         rdData[`INFO_DATA_MSB:`INFO_DATA_LSB] == 16'($past(dCount));
   endproperty
   a_fill_info: assert property (p_fill_info) else $error("fill info mismatch");

   property p_underrun;
      underrun |=> rxErrorFlag [*3];
   endproperty
   a_underrun: assert property (p_underrun) else $error("underrun not flagged");

   property p_flag_sticky;
      rxErrorFlag && !softRst |=> rxErrorFlag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("error flag dropped");

   property p_lead_words;
      state == rx_fifo_pkg::ST_LEAD ##1 state == rx_fifo_pkg::ST_DATA |->
         leadCnt == cfgOffset[`CFG_OFFSET_WORD_MSB:`CFG_OFFSET_WORD_LSB];
   endproperty
   a_lead_words: assert property (p_lead_words) else $error("wrong lead filler count");

   property p_pad_align;
      dWe && dLast && cfgPadEn |=> burstCnt == 6'h00;
   endproperty
   a_pad_align: assert property (p_pad_align) else $error("packet not burst aligned");

   property p_ffwd_done;
      ffwdBit && dCount != '0 && dQ[32] |=> !ffwdBit && dRd == $past(dRd) + (DATA_AW+1)'(1);
   endproperty
   a_ffwd_done: assert property (p_ffwd_done) else $error("fast-forward did not end");

   property p_ffwd_status;
      ffwdBit && !hostStatRd |=> sRd == $past(sRd);
   endproperty
   a_ffwd_status: assert property (p_ffwd_status) else $error("status moved by ffwd");

   property p_dump;
      dumpBit |=> dWr == '0 && dRd == '0 && sWr == '0 && sRd == '0 && !dumpBit;
   endproperty
   a_dump: assert property (p_dump) else $error("dump incomplete");

   property p_status_bits;
      sWe |-> !statWord[31] && !statWord[14]
         && statWord[15] == (statWord[11] | statWord[7] | statWord[6] | statWord[1]);
   endproperty
   a_status_bits: assert property (p_status_bits) else $error("bad status word");

   property p_halt_pulse;
      rxHaltIrq |-> !rxEnable ##1 !rxHaltIrq;
   endproperty
   a_halt_pulse: assert property (p_halt_pulse) else $error("halt irq not a pulse");

endmodule

// ===== verif/mac_frame_source.sv
// Frame source standing in for the MAC interface layer.
`timescale 1ns/10ps
module mac_frame_source (
   // Clock
   input wire logic clk,
   // Byte link
   input wire logic rxReady,
   output rx_fifo_pkg::rx_byte_t macByte,
   output rx_fifo_pkg::frame_flags_t macFlags
);
   initial begin
      macByte = '0;
      macFlags = '0;
   end
   // Bytes count up from 10h; idle lines show the inverse so stale values never match.
   task automatic send(input int len, input rx_fifo_pkg::frame_flags_t fl, output bit ok);
      int n;
      ok = 1;
      // Wait one edge first, so the idle level left by the previous frame stands for a cycle.
      @(posedge clk);
      for (int i = 0; i < len; i++) begin
         macByte <= '{valid: 1'b1, last: (i == len - 1), data: 8'(i + 16)};
         macFlags <= (i == len - 1) ? fl : ~fl;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (!rxReady && n < 100);
         if (n >= 100)
            ok = 0;
      end
      macByte <= '{valid: 1'b0, last: 1'b1, data: ~8'(len + 15)};
      macFlags <= ~fl;
   endtask
endmodule

// ===== verif/ethernet_rx_fifo_host_path_test.sv
// Self-checking bench for the receive FIFO path.
`timescale 1ns/10ps
`include "rx_fifo_cfg.svh"
module ethernet_rx_fifo_host_path_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   rx_fifo_pkg::rx_byte_t macByte;
   rx_fifo_pkg::frame_flags_t macFlags;
   rx_fifo_pkg::host_req_t hostReq = '0;
   logic rxReady;
   logic rxErrorFlag;
   logic rxHaltIrq;
   logic [31:0] rdData;
   int numErrors = 0;
   int cmpCount = 0;
   always #2 clk = ~clk;
   rx_fifo_path DUT (.clk(clk), .rst_n(rst_n), .macByte(macByte), .macFlags(macFlags),
      .rxReady(rxReady), .hostReq(hostReq), .rdData(rdData), .rxErrorFlag(rxErrorFlag),
      .rxHaltIrq(rxHaltIrq));
   mac_frame_source mac (.clk(clk), .rxReady(rxReady), .macByte(macByte), .macFlags(macFlags));
   // ==========================================================================
   // Helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
      if (numErrors == 0 && cmpCount > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hostReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      hostReq <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      hostReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk);
      hostReq <= '0;
      #1 d = rdData;
   endtask
   task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(what, d, exp);
   endtask
   task automatic frame(input int len, input rx_fifo_pkg::frame_flags_t fl);
      bit ok;
      mac.send(len, fl, ok);
      if (!ok) begin
         numErrors++;
         conclude();
      end
   endtask
   // Polls the fill info until the status count arrives; a stuck path ends the run.
   task automatic waitStat(input int n);
      logic [31:0] d;
      int k = 0;
      do begin
         rd(`ADDR_FILL_INFO, d);
         k++;
      end while (d[23:16] !== 8'(n) && k < 40);
      if (d[23:16] !== 8'(n)) begin
         numErrors++;
         conclude();
      end
   endtask
   function automatic logic [31:0] statusWord(input int len, input rx_fifo_pkg::frame_flags_t f);
      return {1'b0, f.filterFail, 14'(len), f.runt | f.tooLong | f.lateColl | f.crcErr, 1'b0,
         f.broadcast, f.lengthErr, f.runt, f.multicast, 2'b00, f.tooLong, f.lateColl,
         f.frameType, f.watchdog, f.miiErr, f.dribble, f.crcErr, 1'b0};
   endfunction
   // ==========================================================================
   // Scenarios
   task automatic tReset();
      rdChk("config", `ADDR_RX_CONFIG, 32'h0000_0400);
      rdChk("info", `ADDR_FILL_INFO, 32'h0000_0000);
      rdChk("unmapped", 8'h40, 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic tStatus();
      int pos[6] = '{8, 6, 5, 0, 11, 10};
      wr(`ADDR_MAC_CONTROL, 32'h0000_0004);
      foreach (pos[i])
         frame(4, 12'h001 << pos[i]);
      waitStat(6);
      rdChk("info", `ADDR_FILL_INFO, 32'h0006_0006);
      foreach (pos[i])
         rdChk("status", `ADDR_RX_STATUS_PORT, statusWord(4, 12'h001 << pos[i]));
      rdChk("info", `ADDR_FILL_INFO, 32'h0000_0006);
      foreach (pos[i])
         rdChk("data", `ADDR_RX_DATA_PORT, 32'h1312_1110);
      rdChk("info", `ADDR_FILL_INFO, 32'h0000_0000);
      $display("test status done");
   endtask
   task automatic tPad();
      logic [31:0] d;
      wr(`ADDR_RX_CONFIG, 32'h0000_0484);
      frame(5, '0);
      frame(5, '0);
      waitStat(2);
      rdChk("info", `ADDR_FILL_INFO, 32'h0002_0008);
      repeat (2) begin
         rdChk("status", `ADDR_RX_STATUS_PORT, statusWord(5, '0));
         rd(`ADDR_RX_DATA_PORT, d);
         rdChk("data", `ADDR_RX_DATA_PORT, 32'h1312_1110);
         rd(`ADDR_RX_DATA_PORT, d);
         check("tail", {24'h0, d[7:0]}, 32'h0000_0014);
         rd(`ADDR_RX_DATA_PORT, d);
      end
      rdChk("info", `ADDR_FILL_INFO, 32'h0000_0000);
      $display("test pad done");
   endtask
   task automatic tFfwd();
      logic [31:0] d;
      int k = 0;
      wr(`ADDR_RX_CONFIG, 32'h0000_0400);
      frame(16, '0);
      frame(16, '0);
      waitStat(2);
      wr(`ADDR_DP_CONTROL, 32'h8000_0000);
      do begin
         rd(`ADDR_DP_CONTROL, d);
         k++;
      end while (d[31] !== 1'b0 && k < 40);
      if (d[31] !== 1'b0) begin
         numErrors++;
         conclude();
      end
      check("ffwd bit", d, 32'h0000_0000);
      rdChk("info", `ADDR_FILL_INFO, 32'h0002_0004);
      rdChk("status", `ADDR_RX_STATUS_PORT, statusWord(16, '0));
      rdChk("data", `ADDR_RX_DATA_PORT, 32'h1312_1110);
      repeat (3)
         rd(`ADDR_RX_DATA_PORT, d);
      rdChk("status", `ADDR_RX_STATUS_PORT, statusWord(16, '0));
      $display("test ffwd done");
   endtask
   task automatic tDump();
      int k = 0;
      frame(8, '0);
      waitStat(1);
      wr(`ADDR_MAC_CONTROL, 32'h0000_0000);
      do begin
         @(posedge clk);
         k++;
      end while (rxHaltIrq !== 1'b1 && k < 50);
      if (rxHaltIrq !== 1'b1) begin
         numErrors++;
         conclude();
      end
      check("halt irq", {31'h0, rxHaltIrq}, 32'h0000_0001);
      rdChk("halted", `ADDR_PATH_STATUS, 32'h0000_0002);
      wr(`ADDR_RX_CONFIG, 32'h0000_8400);
      rdChk("info", `ADDR_FILL_INFO, 32'h0000_0000);
      rdChk("config", `ADDR_RX_CONFIG, 32'h0000_0400);
      $display("test dump done");
   endtask
   task automatic tUnderrun();
      logic [31:0] d;
      rdChk("empty read", `ADDR_RX_STATUS_PORT, 32'h0000_0000);
      check("error flag", {31'h0, rxErrorFlag}, 32'h0000_0001);
      rd(`ADDR_PATH_STATUS, d);
      check("error bit", {31'h0, d[0]}, 32'h0000_0001);
      wr(`ADDR_SOFT_RESET, 32'h0000_0001);
      repeat (2) @(posedge clk);
      #1 check("error flag", {31'h0, rxErrorFlag}, 32'h0000_0000);
      rdChk("config", `ADDR_RX_CONFIG, 32'h0000_0400);
      rdChk("empty data", `ADDR_RX_DATA_PORT, 32'h0000_0000);
      check("data underrun", {31'h0, rxErrorFlag}, 32'h0000_0001);
      wr(`ADDR_SOFT_RESET, 32'h0000_0001);
      repeat (2) @(posedge clk);
      #1 check("error clear", {31'h0, rxErrorFlag}, 32'h0000_0000);
      // Seventeen frames with no status reads overflow the sixteen-entry status FIFO.
      wr(`ADDR_MAC_CONTROL, 32'h0000_0004);
      repeat (17)
         frame(4, '0);
      repeat (2) @(posedge clk);
      #1 check("overrun", {31'h0, rxErrorFlag}, 32'h0000_0001);
      $display("test underrun done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      tReset();
      tStatus();
      tPad();
      tFfwd();
      tDump();
      tUnderrun();
      conclude();
   end
endmodule
